// ### src/setpoint_consts.svh
`ifndef SETPOINT_CONSTS_SVH
`define SETPOINT_CONSTS_SVH
`define OFS_CTRL       10'h000
`define OFS_STATUS     10'h004
`define OFS_LATCH      10'h008
`define OFS_IRQ_ST     10'h00c
`define OFS_IRQ_MASK   10'h010
`define OFS_RLY_CMD    10'h014
`define OFS_RLY_MODE   10'h018
`define OFS_CNT_BASE   8'h02
`define SP_REGION      2'h1
`define SP_W_CFG       2'h0
`define SP_W_OPTHR     2'h1
`define SP_W_RELTHR    2'h2
`define SP_W_DLY       2'h3
`define CTRL_EN_BIT    0
`define CTRL_60HZ_BIT  1
`define DLY_REL_LSB    16
`define DLY_W          14
`define CLK_KHZ        40000
`define SCAN_50_US     20000
`define SCAN_60_US     16600
`define DLY_UNIT_US    100000
`define TIME_RES_US    360000000
`endif

// ### src/setpoint_pkg.sv
`default_nettype none
package setpoint_pkg;
    typedef enum logic [1:0] {
        ACT_NONE  = 2'h0,
        ACT_RELAY = 2'h1,
        ACT_COUNT = 2'h2,
        ACT_TIME  = 2'h3
    } action_e;

    typedef enum logic [1:0] {
        SCAN_IDLE = 2'b01,
        SCAN_EVAL = 2'b10
    } scan_e;

    typedef struct packed {
        logic [1:0] target;
        action_e    action;
        logic       pol_on;
        logic       dir_over;
        logic       binary;
        logic [3:0] src;
    } sp_cfg_s;

    typedef logic [7:0][15:0] an_bus_t;
endpackage
`default_nettype wire

// ### src/setpoint_alarm_controller.sv
// How it works
// - operate delay 0.1-999.9 s before operating
// - release delay 0.1-999.9 s before releasing
// - analog release threshold gives hysteresis
// - equal thresholds mean no dead band
// - binary triggers test on or off
// - binary events are level sensitive
// - status changes only after continuous delay
// - every status change updates status register
// - operated status latched until cleared
// - count action runs only on assertion transition
// - relay is OR of linked setpoints
// - relay holds until all release, latched needs command
// - time action accumulates operated time, 0.1 h
// - sixteen setpoints, one trigger each
// - all setpoints scanned once per line cycle
// - operate threshold makes analog expression true
`timescale 1ns/1ps
`default_nettype none
`include "setpoint_consts.svh"
module setpoint_alarm_controller #(
    parameter int N_SP        = 16,
    parameter int N_RLY       = 4,
    parameter int N_CNT       = 4,
    parameter int SCAN_CYC_50 = `SCAN_50_US * (`CLK_KHZ / 1000),
    parameter int SCAN_CYC_60 = `SCAN_60_US * (`CLK_KHZ / 1000),
    parameter int TENTH_HR_50 = `TIME_RES_US / `SCAN_50_US,
    parameter int TENTH_HR_60 = `TIME_RES_US / `SCAN_60_US
) (
    input  wire logic                  i_sys_clk,
    input  wire logic                  i_rst_n,
    input  wire logic [9:0]            i_addr,
    input  wire logic [31:0]           i_wdata,
    input  wire logic                  i_wr,
    input  wire logic                  i_rd,
    output logic      [31:0]           o_rdata,
    input  wire setpoint_pkg::an_bus_t i_analog,
    input  wire logic [7:0]            i_digital,
    input  wire logic                  i_display_clear,
    output logic      [N_RLY-1:0]      o_relay,
    output logic                       o_irq
);
    import setpoint_pkg::*;

    localparam logic [2:0] K_50 = 3'(`DLY_UNIT_US / `SCAN_50_US);
    localparam logic [2:0] K_60 = 3'(`DLY_UNIT_US / `SCAN_60_US);

    logic [1:0]        ctrl;
    logic [N_SP-1:0]   status;
    logic [N_SP-1:0]   alarm_latch;
    logic [N_SP-1:0]   irq_st;
    logic [N_SP-1:0]   irq_mask;
    logic [N_RLY-1:0]  rly_mode;
    logic [N_RLY-1:0]  rly_hold;
    logic [31:0]       counter [N_CNT];
    sp_cfg_s           cfg     [N_SP];
    logic signed [15:0] op_thr [N_SP];
    logic signed [15:0] rel_thr[N_SP];
    logic [`DLY_W-1:0] op_dly  [N_SP];
    logic [`DLY_W-1:0] rel_dly [N_SP];
    logic [16:0]       dcnt    [N_SP];
    logic [14:0]       tacc    [N_SP];
    scan_e             state;
    logic [3:0]        idx;
    logic [19:0]       scan_cnt;

    // register decode
    wire sp_hit  = i_addr[9:8] == `SP_REGION;
    wire [3:0] sp_sel = i_addr[7:4];
    wire [1:0] sp_w   = i_addr[3:2];
    wire cnt_hit = i_addr[9:4] == 6'(`OFS_CNT_BASE) && i_addr[1:0] == 2'h0;
    wire [1:0] cnt_sel = i_addr[3:2];
    wire wr_ctrl  = i_wr && i_addr == `OFS_CTRL;
    wire wr_latch = i_wr && i_addr == `OFS_LATCH;
    wire wr_irq   = i_wr && i_addr == `OFS_IRQ_ST;
    wire wr_mask  = i_wr && i_addr == `OFS_IRQ_MASK;
    wire wr_rcmd  = i_wr && i_addr == `OFS_RLY_CMD;
    wire wr_rmode = i_wr && i_addr == `OFS_RLY_MODE;
    wire wr_cnt   = i_wr && cnt_hit;
    wire wr_sp    = i_wr && sp_hit && i_addr[1:0] == 2'h0;

    // scan timer: one pass over all setpoints per line cycle
    wire line60 = ctrl[`CTRL_60HZ_BIT];
    wire [19:0] scan_last = line60 ? 20'(SCAN_CYC_60 - 1) : 20'(SCAN_CYC_50 - 1);
    wire scan_tick = ctrl[`CTRL_EN_BIT] && scan_cnt >= scan_last;
    wire eval = state == SCAN_EVAL;

    // current setpoint evaluation
    sp_cfg_s c;
    assign c = cfg[idx];
    wire signed [15:0] val = i_analog[c.src[2:0]];
    wire bin_bit = c.src[3] ? o_relay[c.src[1:0]] : i_digital[c.src[2:0]];
    wire st_cur  = status[idx];
    wire op_met  = c.binary ? (bin_bit == c.pol_on)
                            : (c.dir_over ? val >= op_thr[idx] : val <= op_thr[idx]);
    wire rel_met = c.binary ? (bin_bit != c.pol_on)
                            : (c.dir_over ? val < rel_thr[idx] : val > rel_thr[idx]);
    wire cond = st_cur ? rel_met : op_met;
    wire [2:0] k_scan = line60 ? K_60 : K_50;
    // widened before the product: the longest delay at 60 Hz needs all 17 bits
    wire [16:0] lim = (st_cur ? 17'(rel_dly[idx]) : 17'(op_dly[idx])) * 17'(k_scan);
    wire [16:0] dnext = dcnt[idx] + 17'h1;
    wire flip = eval && cond && dnext >= lim;
    wire rise = flip && !st_cur;
    wire [N_SP-1:0] sp_bit = N_SP'(1) << idx;
    wire [N_SP-1:0] rise_v = rise ? sp_bit : '0;

    // time accumulation in scans; one tenth of an hour then bumps the counter
    wire [14:0] tenth = line60 ? 15'(TENTH_HR_60) : 15'(TENTH_HR_50);
    wire [14:0] tnext = tacc[idx] + 15'h1;
    wire time_on = eval && st_cur && c.action == ACT_TIME;
    wire time_inc = time_on && tnext >= tenth;
    wire cnt_inc = (rise && c.action == ACT_COUNT) || time_inc;

    function automatic logic linked(input int s, input int r);
        linked = status[s] && cfg[s].action == ACT_RELAY && cfg[s].target == 2'(r);
    endfunction

    logic [N_RLY-1:0] relay_or;
    genvar gr;
    generate
        for (gr = 0; gr < N_RLY; gr++) begin : g_rly
            logic [N_SP-1:0] lk;
            for (genvar gs = 0; gs < N_SP; gs++) begin : g_sp
                assign lk[gs] = linked(gs, gr);
            end
            assign relay_or[gr] = |lk;
        end
    endgenerate

    wire [N_RLY-1:0] rly_release = wr_rcmd ? i_wdata[N_RLY-1:0] : '0;
    // a release command cannot drop a relay whose setpoint is still operated;
    // the hold only builds up in latched mode, so switching to latched mode later
    // cannot bring back an operation that has long ended
    wire [N_RLY-1:0] next_hold = ((rly_hold & ~rly_release) | relay_or) & rly_mode;
    wire [N_RLY-1:0] next_relay = relay_or | (rly_hold & rly_mode);

    logic [31:0] rd_val;
    always_comb begin
        rd_val = '0;
        if (sp_hit) begin
            unique case (sp_w)
                `SP_W_CFG:    rd_val = 32'(cfg[sp_sel]);
                `SP_W_OPTHR:  rd_val = 32'(op_thr[sp_sel]);
                `SP_W_RELTHR: rd_val = 32'(rel_thr[sp_sel]);
                `SP_W_DLY:    rd_val = {2'h0, rel_dly[sp_sel], 2'h0, op_dly[sp_sel]};
            endcase
        end else if (cnt_hit) begin
            rd_val = counter[cnt_sel];
        end else begin
            unique case (i_addr)
                `OFS_CTRL:     rd_val = 32'(ctrl);
                `OFS_STATUS:   rd_val = 32'(status);
                `OFS_LATCH:    rd_val = 32'(alarm_latch);
                `OFS_IRQ_ST:   rd_val = 32'(irq_st);
                `OFS_IRQ_MASK: rd_val = 32'(irq_mask);
                `OFS_RLY_CMD:  rd_val = 32'(o_relay);
                `OFS_RLY_MODE: rd_val = 32'(rly_mode);
                default:       rd_val = '0;
            endcase
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ctrl     <= '0;
            irq_mask <= '0;
            rly_mode <= '0;
            o_rdata  <= '0;
        end else begin
            if (wr_ctrl) ctrl <= i_wdata[1:0];
            if (wr_mask) irq_mask <= i_wdata[N_SP-1:0];
            if (wr_rmode) rly_mode <= i_wdata[N_RLY-1:0];
            o_rdata <= i_rd ? rd_val : '0;
        end
    end

    // scan sequencer: setpoints handled one per clock
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state    <= SCAN_IDLE;
            idx      <= '0;
            scan_cnt <= '0;
        end else begin
            scan_cnt <= scan_tick || !ctrl[`CTRL_EN_BIT] ? '0 : scan_cnt + 20'h1;
            unique case (state)
                SCAN_IDLE: if (scan_tick) begin
                    state <= SCAN_EVAL;
                    idx   <= '0;
                end
                SCAN_EVAL: begin
                    idx <= idx + 4'h1;
                    if (idx == 4'(N_SP - 1)) state <= SCAN_IDLE;
                end
            endcase
        end
    end

    // flags: hardware set wins over a software clear in the same cycle
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            status      <= '0;
            alarm_latch <= '0;
            irq_st      <= '0;
            rly_hold    <= '0;
            o_relay     <= '0;
            o_irq       <= 1'b0;
        end else begin
            if (flip) status <= status ^ sp_bit;
            alarm_latch <= (alarm_latch & ~(wr_latch ? i_wdata[N_SP-1:0] : '0)
                            & ~{N_SP{i_display_clear}}) | rise_v;
            irq_st   <= (irq_st & ~(wr_irq ? i_wdata[N_SP-1:0] : '0)) | rise_v;
            rly_hold <= next_hold;
            o_relay  <= next_relay;
            o_irq    <= |(irq_st & irq_mask);
        end
    end

    // per-setpoint settings, written only through the register port
    always_ff @(posedge i_sys_clk) begin
        if (wr_sp) begin
            unique case (sp_w)
                `SP_W_CFG:    cfg[sp_sel] <= i_wdata[$bits(sp_cfg_s)-1:0];
                `SP_W_OPTHR:  op_thr[sp_sel] <= i_wdata[15:0];
                `SP_W_RELTHR: rel_thr[sp_sel] <= i_wdata[15:0];
                `SP_W_DLY: begin
                    op_dly[sp_sel]  <= i_wdata[`DLY_W-1:0];
                    rel_dly[sp_sel] <= i_wdata[`DLY_REL_LSB +: `DLY_W];
                end
            endcase
        end
    end

    // accumulators are cleared at reset: an unknown count would make the first
    // evaluation of every setpoint whose condition is met unknown, whatever its delay
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            for (int i = 0; i < N_SP; i++) begin
                dcnt[i] <= '0;
                tacc[i] <= '0;
            end
        end else if (eval) begin
            dcnt[idx] <= (cond && !flip) ? dnext : '0;
            tacc[idx] <= time_inc || !time_on ? '0 : tnext;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            for (int i = 0; i < N_CNT; i++) begin
                counter[i] <= '0;
            end
        end else if (wr_cnt) begin
            counter[cnt_sel] <= i_wdata;
        end else if (cnt_inc) begin
            counter[c.target] <= counter[c.target] + 32'h1;
        end
    end

    sequence s_count_rise;
        eval && rise && c.action == ACT_COUNT && !wr_cnt;
    endsequence

    sequence s_dropout;
        eval && !cond;
    endsequence

    sequence s_time_tick;
        time_inc && !wr_cnt;
    endsequence

    sequence s_release_start;
        eval && st_cur && rel_met && dcnt[idx] == 17'h0 && rel_dly[idx] != '0;
    endsequence

    sequence s_flat_release;
        eval && !c.binary && st_cur && op_thr[idx] == rel_thr[idx] && !op_met && rel_dly[idx] == '0;
    endsequence

    hold_until_met_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        eval && !cond |=> $stable(status)) else $error("status changed without its condition");
    delay_restart_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        s_dropout |=> dcnt[$past(idx)] == 17'h0) else $error("delay count not restarted");
    latch_follows_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        ((status & ~$past(status)) & ~alarm_latch) == '0) else $error("operated status not latched");
    scan_only_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        status != $past(status) |-> $past(state) == SCAN_EVAL) else $error("status changed outside a scan");
    relay_or_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        ($past(relay_or) & ~o_relay) == '0) else $error("linked setpoint did not drive relay");
    relay_release_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        (~$past(relay_or) & ~$past(rly_mode) & o_relay) == '0) else $error("unlatched relay held");
    binary_level_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        eval && c.binary && st_cur && bin_bit == c.pol_on |=> status[$past(idx)])
        else $error("binary event released while level present");
    count_action_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        s_count_rise |=> counter[$past(c.target)] == $past(counter[c.target]) + 32'h1)
        else $error("count action not performed on assertion");
    no_delay_op_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        eval && !st_cur && op_met && op_dly[idx] == '0 |=> status[$past(idx)])
        else $error("zero delay setpoint did not operate");

    // report, latch and interrupt bookkeeping
    status_read_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        i_rd && i_addr == `OFS_STATUS |=> o_rdata == 32'($past(status)))
        else $error("status register read wrong");
    status_irq_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        ((status & ~$past(status)) & ~irq_st) == '0)
        else $error("status rise left no interrupt flag");
    latch_clear_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        ($past(alarm_latch) & ~alarm_latch) != '0 |-> $past(wr_latch || i_display_clear))
        else $error("alarm latch dropped without a clear");

    // evaluation and delay timing
    release_wait_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        s_release_start |=> status[$past(idx)])
        else $error("release delay skipped");
    hyst_hold_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        eval && !c.binary && st_cur && !rel_met |=> status[$past(idx)])
        else $error("analog setpoint released inside its dead band");
    flat_band_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        s_flat_release |=> !status[$past(idx)])
        else $error("equal limits kept a dead band");
    binary_off_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        eval && c.binary && st_cur && bin_bit != c.pol_on && rel_dly[idx] == '0 |=> !status[$past(idx)])
        else $error("binary setpoint ignored its off level");
    op_thresh_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        eval && !c.binary && !st_cur && !op_met |=> !status[$past(idx)])
        else $error("analog setpoint operated short of its threshold");

    // actions and scan order
    time_count_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        s_time_tick |=> counter[$past(c.target)] == $past(counter[c.target]) + 32'h1)
        else $error("time action did not advance its counter");
    count_release_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        eval && flip && st_cur && c.action == ACT_COUNT && !wr_cnt
            |=> counter[$past(c.target)] == $past(counter[c.target]))
        else $error("count action ran on release");
    latch_relay_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        ($past(rly_hold & rly_mode & ~rly_release) & ~rly_hold) == '0)
        else $error("latched relay dropped without a release command");
    scan_start_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        $rose(eval) |-> $past(scan_tick) && idx == 4'h0)
        else $error("scan began off the line cycle tick");
    scan_full_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        $fell(eval) |-> $past(idx) == 4'(N_SP - 1))
        else $error("scan ended before the last setpoint");
endmodule
`default_nettype wire

// ### bench/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import setpoint_pkg::*;
    // scan period shortened so that multi-scan delays stay cheap
    localparam int SC = 40;
    logic        i_sys_clk       = 1'b0;
    logic        i_rst_n         = 1'b0;
    logic [9:0]  i_addr          = 10'h000;
    logic [31:0] i_wdata         = 32'h0;
    logic        i_wr            = 1'b0;
    logic        i_rd            = 1'b0;
    logic [31:0] o_rdata;
    an_bus_t     i_analog        = '0;
    logic [7:0]  i_digital       = 8'h00;
    logic        i_display_clear = 1'b0;
    logic [3:0]  o_relay;
    logic        o_irq;
    int          err_count       = 0;
    int          n_compared      = 0;
    logic [31:0] rd_val;
    logic [31:0] held;
    logic [9:0]  base;

    always #12.5 i_sys_clk = ~i_sys_clk;

    setpoint_alarm_controller #(.SCAN_CYC_50(SC), .SCAN_CYC_60(35), .TENTH_HR_50(4), .TENTH_HR_60(5)) DUT (
        .i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
        .i_rd(i_rd), .o_rdata(o_rdata), .i_analog(i_analog), .i_digital(i_digital),
        .i_display_clear(i_display_clear), .o_relay(o_relay), .o_irq(o_irq));

    task automatic results();
        if (err_count == 0 && n_compared > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value at %0t: %s got %h exp %h", $time, m, got, exp);
        end
    endtask

    // strobe is dropped one edge before the next access may raise it again
    task automatic wr(input logic [9:0] a, input logic [31:0] d);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= 1'b1;
        @(posedge i_sys_clk);
        i_wr <= 1'b0;
        @(posedge i_sys_clk);
    endtask

    task automatic rd(input logic [9:0] a);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_sys_clk);
        i_rd <= 1'b0;
        #1 rd_val = o_rdata;
        @(posedge i_sys_clk);
    endtask

    task automatic rchk(input logic [9:0] a, input logic [31:0] exp, input string m);
        rd(a);
        chk(rd_val, exp, m);
    endtask

    task automatic pins(input logic [3:0] rly, input logic irq);
        #1;
        chk({28'h0, o_relay}, {28'h0, rly}, "relay");
        chk({31'h0, o_irq}, {31'h0, irq}, "irq");
        @(posedge i_sys_clk);
    endtask

    task automatic scans(input int n);
        repeat (n * SC) @(posedge i_sys_clk);
    endtask

    task automatic t_reset();
        rchk(10'h000, 32'h0, "ctrl");
        rchk(10'h004, 32'h0, "status");
        rchk(10'h008, 32'h0, "latch");
        rchk(10'h3fc, 32'h0, "unmapped");
        pins(4'h0, 1'b0);
    endtask

    // sp0 analog over 100/50 relay0, sp1 binary delayed count, sp2 analog under 0/0 time, sp3 binary relay0
    task automatic t_config();
        for (int s = 0; s < 16; s++) begin
            base = 10'h100 + 10'(s * 16);
            wr(base, s == 0 ? 32'h0a0 : s == 1 ? 32'h150 : s == 2 ? 32'h381 : s == 3 ? 32'h0d1 : 32'h057);
            wr(base + 10'h4, s == 0 ? 32'h64 : 32'h0);
            wr(base + 10'h8, s == 0 ? 32'h32 : 32'h0);
            wr(base + 10'hc, s == 1 ? 32'h0001_0001 : 32'h0);
        end
        wr(10'h010, 32'h1);
        wr(10'h000, 32'h1);
    endtask

    task automatic t_hyst();
        i_analog[0] <= 16'h0078;
        scans(2);
        rchk(10'h004, 32'h1, "operate");
        pins(4'h1, 1'b1);
        i_analog[0] <= 16'h0050;
        scans(2);
        rchk(10'h004, 32'h1, "dead band");
        i_analog[0] <= 16'h0028;
        scans(2);
        rchk(10'h004, 32'h0, "release");
        rchk(10'h008, 32'h1, "latched");
        wr(10'h00c, 32'h1);
        pins(4'h0, 1'b0);
        wr(10'h008, 32'h1);
        rchk(10'h008, 32'h0, "latch w1c");
    endtask

    task automatic t_or();
        i_digital[1] <= 1'b1;
        i_analog[0] <= 16'h0078;
        scans(2);
        rchk(10'h004, 32'h9, "both");
        i_analog[0] <= 16'h0028;
        scans(2);
        rchk(10'h014, 32'h1, "relay held");
        i_digital[1] <= 1'b0;
        scans(2);
        pins(4'h0, 1'b1);
        rchk(10'h008, 32'h9, "latch both");
        i_display_clear <= 1'b1;
        @(posedge i_sys_clk);
        i_display_clear <= 1'b0;
        @(posedge i_sys_clk);
        rchk(10'h008, 32'h0, "display clear");
        wr(10'h018, 32'h1);
        i_digital[1] <= 1'b1;
        scans(2);
        i_digital[1] <= 1'b0;
        scans(2);
        pins(4'h1, 1'b1);
        wr(10'h014, 32'h1);
        pins(4'h0, 1'b1);
        wr(10'h00c, 32'hffff);
    endtask

    task automatic t_delay();
        i_digital[0] <= 1'b1;
        scans(3);
        i_digital[0] <= 1'b0;
        scans(1);
        i_digital[0] <= 1'b1;
        scans(4);
        rchk(10'h004, 32'h0, "dropout restart");
        scans(3);
        rchk(10'h004, 32'h2, "operate delay");
        scans(3);
        rchk(10'h020, 32'h1, "count once");
        rchk(10'h00c, 32'h2, "irq status");
        pins(4'h0, 1'b0);
        i_digital[0] <= 1'b0;
        scans(3);
        rchk(10'h004, 32'h2, "release pending");
        scans(3);
        rchk(10'h004, 32'h0, "release delay");
    endtask

    task automatic t_time();
        i_analog[1] <= 16'hfffb;
        scans(10);
        rchk(10'h004, 32'h4, "under");
        rchk(10'h024, 32'h2, "time count");
        i_analog[1] <= 16'h0000;
        scans(2);
        rchk(10'h004, 32'h4, "equal limits");
        i_analog[1] <= 16'h0001;
        scans(2);
        rchk(10'h004, 32'h0, "no dead band");
        rd(10'h024);
        held = rd_val;
        scans(8);
        rchk(10'h024, held, "time stops");
        wr(10'h024, 32'h0);
        rchk(10'h024, 32'h0, "preset");
        wr(10'h000, 32'h3);
        rchk(10'h000, 32'h3, "ctrl 60");
    endtask

    // 60 Hz scans are shorter and the same delay spans one more of them
    task automatic t_line60();
        i_digital[0] <= 1'b1;
        repeat (5 * 35) @(posedge i_sys_clk);
        rchk(10'h004, 32'h0, "60 Hz pending");
        repeat (2 * 35) @(posedge i_sys_clk);
        rchk(10'h004, 32'h2, "60 Hz operate");
        i_digital[0] <= 1'b0;
    endtask

    task automatic t_rerun();
        i_rst_n <= 1'b0;
        repeat (2) @(posedge i_sys_clk);
        i_rst_n <= 1'b1;
        @(posedge i_sys_clk);
        rchk(10'h004, 32'h0, "status after reset");
        rchk(10'h020, 32'h0, "counter after reset");
        pins(4'h0, 1'b0);
    endtask

    initial begin
        repeat (100000) @(posedge i_sys_clk);
        err_count++;
        results();
    end

    initial begin
        i_analog[1] <= 16'h000a;
        repeat (2) @(posedge i_sys_clk);
        i_rst_n <= 1'b1;
        @(posedge i_sys_clk);
        t_reset();
        t_config();
        t_hyst();
        t_or();
        t_delay();
        t_time();
        t_line60();
        t_rerun();
        results();
    end
endmodule
`default_nettype wire
